// *** hdl/rcst_ahb_slave.sv ***
`timescale 1ns/1ps
// one wait state on every whole-word transfer so that read data leaves a flop
module rcst_ahb_slave (
    input  wire logic               core_clk_in,
    input  wire logic               rst_in,
    input  wire logic               hsel_in,
    input  wire logic [31:0]        haddr_in,
    input  wire logic [1:0]         htrans_in,
    input  wire logic               hwrite_in,
    input  wire logic [2:0]         hsize_in,
    input  wire logic [31:0]        hwdata_in,
    input  wire logic               hready_in,
    input  wire logic               busy_in,
    input  wire logic [31:0]        rdata_in,
    output rcst_pkg::rcst_cmd_t     cmd_out,
    output logic [31:0]             hrdata_out,
    output logic                    hreadyout_out,
    output logic                    hresp_out
);
    logic       pend_q;
    logic       write_q;
    logic [7:0] addr_q;
    logic       take;

    // only whole-word transfers are served; others complete with no effect
    assign take = hsel_in && htrans_in[1] && hready_in && !busy_in
                  && (hsize_in == 3'h2);

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pend_q  <= 1'b0;
            write_q <= 1'b0;
            addr_q  <= 8'h00;
        end else if (take) begin
            pend_q  <= 1'b1;
            write_q <= hwrite_in;
            addr_q  <= {haddr_in[7:2], 2'h0};
        end else begin
            pend_q  <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hreadyout_out <= 1'b0;
            hrdata_out    <= 32'h0000_0000;
        end else begin
            hreadyout_out <= !busy_in && !take;
            if (pend_q && !write_q) begin
                hrdata_out <= rdata_in;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hresp_out <= 1'b0;
        end else begin
            hresp_out <= 1'b0;
        end
    end

    assign cmd_out.wr    = pend_q && write_q;
    assign cmd_out.rd    = pend_q && !write_q;
    assign cmd_out.addr  = addr_q;
    assign cmd_out.wdata = hwdata_in;
endmodule // rcst_ahb_slave

// *** hdl/rcst_pkg.sv ***
package rcst_pkg;

    localparam logic [7:0] REG_CTRL_OFFSET    = 8'h00;
    localparam logic [7:0] REG_STANDBY_OFFSET = 8'h04;
    localparam logic [7:0] REG_THERMAL_OFFSET = 8'h08;
    localparam logic [7:0] REG_STATUS_OFFSET  = 8'h0C;

    localparam int HS_PD_LSB   = 8;
    localparam int LS_LSB      = 10;
    localparam int BOOST_LSB   = 12;
    localparam int PD_OFF_BIT  = 14;
    localparam int HV_ON_BIT   = 15;
    localparam int HV_OFF_BIT  = 16;
    localparam int HS_PU_LSB   = 20;

    localparam int BUCK1_SB_BIT = 8;
    localparam int BUCK2_SB_BIT = 10;
    localparam int BUCK3_SB_BIT = 12;
    localparam int PREV_SB_BIT  = 14;
    localparam int HV_SB_BIT    = 16;
    localparam int LIN1_SB_BIT  = 18;
    localparam int LIN2_SB_BIT  = 20;
    localparam int LIN3_SB_BIT  = 22;

    localparam int ACTION_LSB  = 8;
    localparam int TEMP_LSB    = 16;

    localparam int ST_HV_ON_BIT   = 0;
    localparam int ST_DFS_BIT     = 1;
    localparam int ST_PD_BIT      = 2;
    localparam int ST_STANDBY_BIT = 3;

    localparam logic       PD_OFF_RESET   = 1'b0;
    localparam logic       HV_ON_RESET    = 1'b0;
    localparam logic [6:0] STANDBY_RESET  = 7'h7F;
    localparam logic       PREV_RESET     = 1'b1;
    localparam logic [1:0] SLEW_RESET     = 2'h0;
    localparam logic [2:0] TEMP_RESET     = 3'h0;
    localparam logic [7:0] ACTION_RESET   = 8'h00;

    localparam logic [9:0] DRIVE_MA_0 = 10'h082;
    localparam logic [9:0] DRIVE_MA_1 = 10'h104;
    localparam logic [9:0] DRIVE_MA_2 = 10'h208;
    localparam logic [9:0] DRIVE_MA_3 = 10'h384;
    localparam logic [9:0] BOOST_VUS_0 = 10'h032;
    localparam logic [9:0] BOOST_VUS_1 = 10'h064;
    localparam logic [9:0] BOOST_VUS_2 = 10'h12C;
    localparam logic [9:0] BOOST_VUS_3 = 10'h1F4;
    localparam logic [7:0] TEMP_C_0 = 8'h4B;
    localparam logic [7:0] TEMP_C_1 = 8'h5A;
    localparam logic [7:0] TEMP_C_2 = 8'h69;
    localparam logic [7:0] TEMP_C_3 = 8'h78;
    localparam logic [7:0] TEMP_C_4 = 8'h87;
    localparam logic [7:0] TEMP_C_5 = 8'h96;

    typedef struct packed {
        logic [1:0] hs_pulldown_slew;
        logic [1:0] hs_pullup_slew;
        logic [1:0] ls_slew;
        logic [1:0] boost_slew;
        logic [2:0] die_temp;
        logic [7:0] thermal_action;
    } rcst_otp_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } rcst_cmd_t;

    typedef struct packed {
        logic [9:0] pre_hs_pulldown_ma;
        logic [9:0] pre_hs_pullup_ma;
        logic [9:0] pre_ls_ma;
        logic [9:0] boost_ls_vus;
    } rcst_drive_t;

endpackage

// *** hdl/rcst_regs.sv ***
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module rcst_regs (
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   hsel_in,
    input  wire logic [31:0]            haddr_in,
    input  wire logic [1:0]             htrans_in,
    input  wire logic                   hwrite_in,
    input  wire logic [2:0]             hsize_in,
    input  wire logic [31:0]            hwdata_in,
    input  wire logic                   hready_in,
    output logic [31:0]                 hrdata_out,
    output logic                        hreadyout_out,
    output logic                        hresp_out,
    input  wire rcst_pkg::rcst_otp_t    otp_defaults_in,
    input  wire logic                   pre_standby_voltage_otp_enable_in,
    input  wire logic                   pre_normal_at_3v3_in,
    input  wire logic                   pre_pulldown_auto_in,
    input  wire logic                   standby_mode_in,
    input  wire logic [7:0]             thermal_trip_in,
    output rcst_pkg::rcst_drive_t       drive_out,
    output logic                        pre_pulldown_en_out,
    output logic                        hv_linreg_run_out,
    output logic [6:0]                  rail_standby_keep_out,
    output logic                        pre_standby_3v_out,
    output logic [7:0]                  rail_thermal_off_out,
    output logic                        deep_fail_safe_state_out,
    output logic [7:0]                  die_temp_limit_c_out
);
    rcst_pkg::rcst_cmd_t cmd;
    logic [31:0]         rdata;
    logic                load_q;

    logic [1:0]          pre_hs_pulldown_slew_q;
    logic [1:0]          pre_hs_pullup_slew_q;
    logic [1:0]          pre_ls_slew_q;
    logic [1:0]          boost_ls_slew_q;
    logic                pre_pulldown_force_off_q;
    logic                hv_linreg_on_q;
    logic [6:0]          standby_on_q;
    logic                pre_standby_voltage_sel_q;
    logic [7:0]          thermal_action_q;
    logic [2:0]          die_temp_q;
    logic                dfs_q;

    logic                standby_s1_q;
    logic                standby_s2_q;
    logic [7:0]          trip_s1_q;
    logic [7:0]          trip_s2_q;
    logic [7:0]          trip_s3_q;
    logic [7:0]          trip_rise;

    logic                wr_ctrl;
    logic                wr_standby;
    logic                wr_thermal;

    rcst_ahb_slave u_slave (
        .core_clk_in   (core_clk_in),
        .rst_in        (rst_in),
        .hsel_in       (hsel_in),
        .haddr_in      (haddr_in),
        .htrans_in     (htrans_in),
        .hwrite_in     (hwrite_in),
        .hsize_in      (hsize_in),
        .hwdata_in     (hwdata_in),
        .hready_in     (hready_in),
        .busy_in       (load_q),
        .rdata_in      (rdata),
        .cmd_out       (cmd),
        .hrdata_out    (hrdata_out),
        .hreadyout_out (hreadyout_out),
        .hresp_out     (hresp_out)
    );

    assign wr_ctrl    = cmd.wr && (cmd.addr == rcst_pkg::REG_CTRL_OFFSET);
    assign wr_standby = cmd.wr && (cmd.addr == rcst_pkg::REG_STANDBY_OFFSET);
    assign wr_thermal = cmd.wr && (cmd.addr == rcst_pkg::REG_THERMAL_OFFSET);

    // otp values are taken on the first edge after release, never by the reset itself
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            load_q <= 1'b1;
        end else begin
            load_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            standby_s1_q <= 1'b0;
            standby_s2_q <= 1'b0;
            trip_s1_q    <= 8'h00;
            trip_s2_q    <= 8'h00;
            trip_s3_q    <= 8'h00;
        end else begin
            standby_s1_q <= standby_mode_in;
            standby_s2_q <= standby_s1_q;
            trip_s1_q    <= thermal_trip_in;
            trip_s2_q    <= trip_s1_q;
            trip_s3_q    <= trip_s2_q;
        end
    end

    assign trip_rise = trip_s2_q & ~trip_s3_q;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_hs_pulldown_slew_q <= rcst_pkg::SLEW_RESET;
            pre_hs_pullup_slew_q   <= rcst_pkg::SLEW_RESET;
            pre_ls_slew_q          <= rcst_pkg::SLEW_RESET;
            boost_ls_slew_q        <= rcst_pkg::SLEW_RESET;
        end else if (load_q) begin
            pre_hs_pulldown_slew_q <= otp_defaults_in.hs_pulldown_slew;
            pre_hs_pullup_slew_q   <= otp_defaults_in.hs_pullup_slew;
            pre_ls_slew_q          <= otp_defaults_in.ls_slew;
            boost_ls_slew_q        <= otp_defaults_in.boost_slew;
        end else if (wr_ctrl) begin
            pre_hs_pulldown_slew_q <= cmd.wdata[rcst_pkg::HS_PD_LSB +: 2];
            pre_hs_pullup_slew_q   <= cmd.wdata[rcst_pkg::HS_PU_LSB +: 2];
            pre_ls_slew_q          <= cmd.wdata[rcst_pkg::LS_LSB +: 2];
            boost_ls_slew_q        <= cmd.wdata[rcst_pkg::BOOST_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_pulldown_force_off_q <= rcst_pkg::PD_OFF_RESET;
        end else if (wr_ctrl) begin
            pre_pulldown_force_off_q <= cmd.wdata[rcst_pkg::PD_OFF_BIT];
        end
    end

    // off beats on: a thermal trip on bit 0 or an off request ends an on request in the same cycle
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hv_linreg_on_q <= rcst_pkg::HV_ON_RESET;
        end else if (trip_rise[0]) begin
            hv_linreg_on_q <= 1'b0;
        end else if (wr_ctrl && cmd.wdata[rcst_pkg::HV_OFF_BIT]) begin
            hv_linreg_on_q <= 1'b0;
        end else if (wr_ctrl && cmd.wdata[rcst_pkg::HV_ON_BIT]) begin
            hv_linreg_on_q <= 1'b1;
        end
    end

    // keep order: buck1, buck2, buck3, hv linreg, linreg1, linreg2, linreg3
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            standby_on_q              <= rcst_pkg::STANDBY_RESET;
            pre_standby_voltage_sel_q <= rcst_pkg::PREV_RESET;
        end else if (wr_standby) begin
            standby_on_q <= {cmd.wdata[rcst_pkg::LIN3_SB_BIT],
                             cmd.wdata[rcst_pkg::LIN2_SB_BIT],
                             cmd.wdata[rcst_pkg::LIN1_SB_BIT],
                             cmd.wdata[rcst_pkg::HV_SB_BIT],
                             cmd.wdata[rcst_pkg::BUCK3_SB_BIT],
                             cmd.wdata[rcst_pkg::BUCK2_SB_BIT],
                             cmd.wdata[rcst_pkg::BUCK1_SB_BIT]};
            pre_standby_voltage_sel_q <= cmd.wdata[rcst_pkg::PREV_SB_BIT];
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            thermal_action_q <= rcst_pkg::ACTION_RESET;
            die_temp_q       <= rcst_pkg::TEMP_RESET;
        end else if (load_q) begin
            thermal_action_q <= otp_defaults_in.thermal_action;
            die_temp_q       <= otp_defaults_in.die_temp;
        end else if (wr_thermal) begin
            thermal_action_q <= cmd.wdata[rcst_pkg::ACTION_LSB +: 8];
            die_temp_q       <= cmd.wdata[rcst_pkg::TEMP_LSB +: 3];
        end
    end

    // the fail-safe state is left only through reset
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dfs_q <= 1'b0;
        end else if (|(trip_rise & thermal_action_q)) begin
            dfs_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rail_thermal_off_out     <= 8'h00;
            deep_fail_safe_state_out <= 1'b0;
        end else begin
            rail_thermal_off_out     <= trip_rise;
            deep_fail_safe_state_out <= dfs_q;
        end
    end

    function automatic logic [9:0] drive_ma(input logic [1:0] code);
        case (code)
            2'h0:    drive_ma = rcst_pkg::DRIVE_MA_0;
            2'h1:    drive_ma = rcst_pkg::DRIVE_MA_1;
            2'h2:    drive_ma = rcst_pkg::DRIVE_MA_2;
            default: drive_ma = rcst_pkg::DRIVE_MA_3;
        endcase
    endfunction

    function automatic logic [9:0] boost_vus(input logic [1:0] code);
        case (code)
            2'h0:    boost_vus = rcst_pkg::BOOST_VUS_0;
            2'h1:    boost_vus = rcst_pkg::BOOST_VUS_1;
            2'h2:    boost_vus = rcst_pkg::BOOST_VUS_2;
            default: boost_vus = rcst_pkg::BOOST_VUS_3;
        endcase
    endfunction

    // codes 110 and 111 have no threshold of their own and hold the highest one
    function automatic logic [7:0] temp_c(input logic [2:0] code);
        case (code)
            3'h0:    temp_c = rcst_pkg::TEMP_C_0;
            3'h1:    temp_c = rcst_pkg::TEMP_C_1;
            3'h2:    temp_c = rcst_pkg::TEMP_C_2;
            3'h3:    temp_c = rcst_pkg::TEMP_C_3;
            3'h4:    temp_c = rcst_pkg::TEMP_C_4;
            default: temp_c = rcst_pkg::TEMP_C_5;
        endcase
    endfunction

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            drive_out <= '0;
        end else begin
            drive_out.pre_hs_pulldown_ma <= drive_ma(pre_hs_pulldown_slew_q);
            drive_out.pre_hs_pullup_ma   <= drive_ma(pre_hs_pullup_slew_q);
            drive_out.pre_ls_ma          <= drive_ma(pre_ls_slew_q);
            drive_out.boost_ls_vus       <= boost_vus(boost_ls_slew_q);
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            die_temp_limit_c_out <= 8'h00;
        end else begin
            die_temp_limit_c_out <= temp_c(die_temp_q);
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_pulldown_en_out <= 1'b0;
        end else begin
            pre_pulldown_en_out <= pre_pulldown_auto_in && !pre_pulldown_force_off_q;
        end
    end

    // in standby the hv linreg keeps running only while its standby bit is set
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hv_linreg_run_out <= 1'b0;
        end else begin
            hv_linreg_run_out <= hv_linreg_on_q && !dfs_q
                                 && (!standby_s2_q || standby_on_q[3]);
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rail_standby_keep_out <= rcst_pkg::STANDBY_RESET;
        end else begin
            rail_standby_keep_out <= standby_on_q;
        end
    end

    // a 3 V request is ignored unless otp allows it and normal mode runs at 3.3 V
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_standby_3v_out <= 1'b0;
        end else begin
            pre_standby_3v_out <= pre_standby_voltage_sel_q
                                  && pre_standby_voltage_otp_enable_in
                                  && pre_normal_at_3v3_in;
        end
    end

    // request bits and reserved positions read back as zero
    always_comb begin
        rdata = 32'h0000_0000;
        case (cmd.addr)
            rcst_pkg::REG_CTRL_OFFSET: begin
                rdata[rcst_pkg::HS_PD_LSB +: 2] = pre_hs_pulldown_slew_q;
                rdata[rcst_pkg::HS_PU_LSB +: 2] = pre_hs_pullup_slew_q;
                rdata[rcst_pkg::LS_LSB +: 2]    = pre_ls_slew_q;
                rdata[rcst_pkg::BOOST_LSB +: 2] = boost_ls_slew_q;
                rdata[rcst_pkg::PD_OFF_BIT]     = pre_pulldown_force_off_q;
            end
            rcst_pkg::REG_STANDBY_OFFSET: begin
                rdata[rcst_pkg::BUCK1_SB_BIT] = standby_on_q[0];
                rdata[rcst_pkg::BUCK2_SB_BIT] = standby_on_q[1];
                rdata[rcst_pkg::BUCK3_SB_BIT] = standby_on_q[2];
                rdata[rcst_pkg::HV_SB_BIT]    = standby_on_q[3];
                rdata[rcst_pkg::LIN1_SB_BIT]  = standby_on_q[4];
                rdata[rcst_pkg::LIN2_SB_BIT]  = standby_on_q[5];
                rdata[rcst_pkg::LIN3_SB_BIT]  = standby_on_q[6];
                rdata[rcst_pkg::PREV_SB_BIT]  = pre_standby_voltage_sel_q;
            end
            rcst_pkg::REG_THERMAL_OFFSET: begin
                rdata[rcst_pkg::ACTION_LSB +: 8] = thermal_action_q;
                rdata[rcst_pkg::TEMP_LSB +: 3]   = die_temp_q;
            end
            rcst_pkg::REG_STATUS_OFFSET: begin
                rdata[rcst_pkg::ST_HV_ON_BIT]   = hv_linreg_on_q;
                rdata[rcst_pkg::ST_DFS_BIT]     = dfs_q;
                rdata[rcst_pkg::ST_PD_BIT]      = pre_pulldown_en_out;
                rdata[rcst_pkg::ST_STANDBY_BIT] = standby_s2_q;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

endmodule // rcst_regs

// *** verif/rcst_host_model.sv ***
`timescale 1ns/1ps
module rcst_host_model (
    input  wire logic        core_clk_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_in,
    output logic [31:0]      haddr_out = 32'h0,
    output logic [1:0]       htrans_out = 2'h0,
    output logic             hwrite_out = 1'b0,
    output logic [31:0]      hwdata_out = 32'h0,
    output logic             stuck_out = 1'b0
);
    // call just after a rising edge; stuck stays set once a transfer takes 40 edges in all
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        n = 0;
        haddr_out <= {24'h0, a};
        htrans_out <= 2'h2;
        hwrite_out <= w;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (!hready_in && n < 20);
        htrans_out <= 2'h0;
        hwdata_out <= d;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (!hready_in && n < 40);
        r = hrdata_in;
        stuck_out <= stuck_out | (n >= 40);
    endtask
endmodule // rcst_host_model

// *** verif/rcst_regs_checker.sv ***
`timescale 1ns/1ps
module rcst_regs_checker (
    input wire logic       core_clk_in,
    input wire logic       rst_in,
    input wire logic       hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic       hready_in,
    input wire logic       hreadyout_out,
    input wire logic       pre_pulldown_auto_in,
    input wire logic       pre_pulldown_en_out,
    input wire logic       pre_standby_voltage_otp_enable_in,
    input wire logic       pre_normal_at_3v3_in,
    input wire logic       pre_standby_3v_out,
    input wire logic [7:0] thermal_trip_in,
    input wire logic [7:0] rail_thermal_off_out,
    input wire logic       deep_fail_safe_state_out,
    input wire logic       hv_linreg_run_out,
    input wire logic [6:0] rail_standby_keep_out,
    input wire logic [7:0] die_temp_limit_c_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    a_bus_one_wait: assert property ((hsel_in && htrans_in[1] && hready_in && hreadyout_out)
        |=> !hreadyout_out ##1 hreadyout_out) else $error("wait state wrong");
    a_keep_reset: assert property ($fell(rst_in) |-> rail_standby_keep_out == 7'h7F)
        else $error("standby keep reset wrong");
    a_pd_auto: assert property (pre_pulldown_en_out |-> $past(pre_pulldown_auto_in))
        else $error("pulldown on without auto");
    a_stby_3v_gate: assert property (pre_standby_3v_out |->
        $past(pre_standby_voltage_otp_enable_in && pre_normal_at_3v3_in)) else $error("3v ungated");
    a_trip_delay: assert property ($rose(thermal_trip_in[0]) |-> ##3 rail_thermal_off_out[0])
        else $error("trip pulse late");
    a_pulse_once: assert property (rail_thermal_off_out[7] |=> !rail_thermal_off_out[7])
        else $error("trip pulse too long");
    a_dfs_cause: assert property ($rose(deep_fail_safe_state_out) |->
        $past(rail_thermal_off_out) != 8'h00) else $error("fail-safe without trip");
    a_dfs_sticky: assert property (deep_fail_safe_state_out |=> deep_fail_safe_state_out)
        else $error("fail-safe left");
    a_dfs_hv_off: assert property (deep_fail_safe_state_out |-> !hv_linreg_run_out)
        else $error("hv runs in fail-safe");
    a_temp_code: assert property (die_temp_limit_c_out inside
        {8'h00, 8'h4B, 8'h5A, 8'h69, 8'h78, 8'h87, 8'h96}) else $error("bad temp limit");

    c_trip: cover property (rail_thermal_off_out[0]);
    c_dfs: cover property ($rose(deep_fail_safe_state_out));
    c_3v: cover property (pre_standby_3v_out);
endmodule // rcst_regs_checker

bind rcst_regs rcst_regs_checker chk_i (.core_clk_in, .rst_in, .hsel_in, .htrans_in,
    .hready_in, .hreadyout_out, .pre_pulldown_auto_in, .pre_pulldown_en_out,
    .pre_standby_voltage_otp_enable_in, .pre_normal_at_3v3_in, .pre_standby_3v_out,
    .thermal_trip_in, .rail_thermal_off_out, .deep_fail_safe_state_out, .hv_linreg_run_out,
    .rail_standby_keep_out, .die_temp_limit_c_out);

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic                  core_clk_in = 1'b0;
    logic                  rst_in = 1'b1;
    logic                  hsel_in = 1'b1;
    logic [2:0]            hsize_in = 3'h2;
    logic [31:0]           haddr_in, hwdata_in, hrdata_out;
    logic [1:0]            htrans_in;
    logic                  hwrite_in, hreadyout_out, hresp_out, stuck;
    rcst_pkg::rcst_otp_t   otp_defaults_in = '{2'h1, 2'h2, 2'h3, 2'h0, 3'h5, 8'h01};
    logic                  pre_standby_voltage_otp_enable_in = 1'b1;
    logic                  pre_normal_at_3v3_in = 1'b1;
    logic                  pre_pulldown_auto_in = 1'b1;
    logic                  standby_mode_in = 1'b0;
    logic [7:0]            thermal_trip_in = 8'h00;
    rcst_pkg::rcst_drive_t drive_out;
    logic                  pre_pulldown_en_out, hv_linreg_run_out, pre_standby_3v_out;
    logic                  deep_fail_safe_state_out;
    logic [6:0]            rail_standby_keep_out;
    logic [7:0]            rail_thermal_off_out, die_temp_limit_c_out;
    logic [9:0]            ma [4] = '{10'h082, 10'h104, 10'h208, 10'h384};
    logic [9:0]            vus [4] = '{10'h032, 10'h064, 10'h12C, 10'h1F4};
    int                    errors = 0;
    int                    n_tests = 0;

    always #10 core_clk_in = ~core_clk_in;

    rcst_regs dut (.core_clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
        .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out,
        .hresp_out, .otp_defaults_in, .pre_standby_voltage_otp_enable_in,
        .pre_normal_at_3v3_in, .pre_pulldown_auto_in, .standby_mode_in, .thermal_trip_in,
        .drive_out, .pre_pulldown_en_out, .hv_linreg_run_out, .rail_standby_keep_out,
        .pre_standby_3v_out, .rail_thermal_off_out, .deep_fail_safe_state_out,
        .die_temp_limit_c_out);
    rcst_host_model host (.core_clk_in, .hready_in(hreadyout_out), .hrdata_in(hrdata_out),
        .haddr_out(haddr_in), .htrans_out(htrans_in), .hwrite_out(hwrite_in),
        .hwdata_out(hwdata_in), .stuck_out(stuck));

    task automatic end_sim();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e || stuck) begin
            errors++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
        if (stuck)
            end_sim();
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        host.xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
        logic [31:0] r;
        host.xfer(1'b0, a, 32'h0, r);
        chk(s, e, r);
    endtask
    task automatic hv(input logic [31:0] d, input logic e);
        wr(8'h00, d);
        step(1);
        chk("hv run", 32'(e), 32'(hv_linreg_run_out));
    endtask
    // a held trip must give one pulse only
    task automatic trip(input int b);
        int n;
        n = 0;
        thermal_trip_in[b] <= 1'b1;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (rail_thermal_off_out == 8'h00 && n < 10);
        chk("trip pulse", 32'h1 << b, 32'(rail_thermal_off_out));
        step(1);
        chk("pulse end", 32'h0, 32'(rail_thermal_off_out));
    endtask

    initial begin
        step(12);
        rst_in <= 1'b0;
        step(4);
        rd(8'h00, 32'h00200D00, "ctrl reset");
        rd(8'h04, 32'h00555500, "standby reset");
        rd(8'h08, 32'h00050100, "thermal reset");
        chk("temp limit", 32'h96, 32'(die_temp_limit_c_out));
        chk("keep reset", 32'h7F, 32'(rail_standby_keep_out));
        wr(8'h04, 32'h00555500);
        rd(8'h04, 32'h00555500, "reserved");
        wr(8'h04, 32'h00000000);
        step(1);
        chk("keep off", 32'h0, 32'(rail_standby_keep_out));
        chk("3v off", 32'h0, 32'(pre_standby_3v_out));
        wr(8'h04, 32'h00555500);
        step(1);
        chk("3v on", 32'h1, 32'(pre_standby_3v_out));
        pre_normal_at_3v3_in <= 1'b0;
        step(2);
        chk("3v gated", 32'h0, 32'(pre_standby_3v_out));
        pre_normal_at_3v3_in <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, (32'(c) << 20) | (32'(c) << 12) | (32'(c) << 10) | (32'(c) << 8));
            step(1);
            chk("hs down", 32'(ma[c]), 32'(drive_out.pre_hs_pulldown_ma));
            chk("ls", 32'(ma[c]), 32'(drive_out.pre_ls_ma));
            chk("boost", 32'(vus[c]), 32'(drive_out.boost_ls_vus));
            chk("hs up", 32'(ma[c]), 32'(drive_out.pre_hs_pullup_ma));
        end
        chk("pd auto", 32'h1, 32'(pre_pulldown_en_out));
        pre_pulldown_auto_in <= 1'b0;
        step(2);
        chk("pd auto off", 32'h0, 32'(pre_pulldown_en_out));
        pre_pulldown_auto_in <= 1'b1;
        wr(8'h00, 32'h00004000);
        step(1);
        chk("pd forced", 32'h0, 32'(pre_pulldown_en_out));
        hv(32'h00008000, 1'b1);
        rd(8'h00, 32'h00000000, "request bits");
        hv(32'h00000000, 1'b1);
        hv(32'h00010000, 1'b0);
        hv(32'h00000000, 1'b0);
        hv(32'h00018000, 1'b0);
        hv(32'h00008000, 1'b1);
        standby_mode_in <= 1'b1;
        step(6);
        chk("hv standby", 32'h1, 32'(hv_linreg_run_out));
        wr(8'h04, 32'h00545500);
        step(1);
        chk("hv standby off", 32'h0, 32'(hv_linreg_run_out));
        standby_mode_in <= 1'b0;
        step(6);
        trip(7);
        step(2);
        chk("no fail-safe", 32'h0, 32'(deep_fail_safe_state_out));
        chk("hv kept", 32'h1, 32'(hv_linreg_run_out));
        trip(0);
        step(2);
        chk("fail-safe", 32'h1, 32'(deep_fail_safe_state_out));
        chk("hv tripped", 32'h0, 32'(hv_linreg_run_out));
        rd(8'h0C, 32'h00000006, "status");
        rd(8'h10, 32'h00000000, "unmapped");
        chk("hresp", 32'h0, 32'(hresp_out));
        end_sim();
    end
endmodule // testbench
